// File: design/mcg_clock_map.svh
// offsets-free constants for the master clock generator: codes, limits, band edges, nco width
`ifndef MCG_CLOCK_MAP_SVH
`define MCG_CLOCK_MAP_SVH

// clock source select codes
`define MCG_SRC_PLL 2'h3
// cpu clock ratio when halving
`define MCG_CPU_DIV 2
// divider limits
`define MCG_IDIV_MAX 2'h3
`define MCG_ODIV_MAX 4'hE
// vco band codes
`define MCG_BAND_LOW 2'h0
`define MCG_BAND_MID 2'h1
`define MCG_BAND_HIGH 2'h2
`define MCG_BAND_RSVD 2'h3
// reference clock rate in mhz
`define MCG_REF_MHZ 250
// vco band edges in mhz
`define MCG_VCO_100_MHZ 100
`define MCG_VCO_150_MHZ 150
`define MCG_VCO_200_MHZ 200
`define MCG_VCO_250_MHZ 250
// nco accumulator width
`define MCG_ACC_W 16
// consecutive matched windows before lock
`define MCG_LOCK_WINDOWS 4'h4
// reset values
`define MCG_RST_SRC 2'h0
`define MCG_RST_IDIV 2'h0
`define MCG_RST_ODIV 4'h0
`define MCG_RST_BAND 2'h0

`endif

// File: design/mcg_clock_pkg.sv
// types shared by the master clock generator
package mcg_clock_pkg;

    typedef enum logic {
        MCG_ACQUIRE,
        MCG_LOCKED
    } mcg_lock_state_t;

endpackage : mcg_clock_pkg

// File: design/mcg_edge_div.sv
// edge-driven divide-by-(n+1) stage with pass-through at n = 0
`timescale 1ns/10ps
module mcg_edge_div #(
    parameter int DIV_W = 4
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // incoming clock as level plus rising-edge pulse
    input wire logic i_level,
    input wire logic i_rise,
    // divide setting, ratio is value plus one
    input wire logic [DIV_W-1:0] i_div,
    // divided clock
    output logic o_level,
    output logic o_rise
);

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;
    logic next_level;
    logic next_rise;
    logic [DIV_W:0] half;
    logic wrap;

    always_comb begin
        half = ({1'b0, i_div} + {{DIV_W{1'b0}}, 1'b1}) >> 1;
        wrap = (cnt >= i_div);
        next_cnt = cnt;
        next_rise = 1'b0;
        if (i_rise) begin
            next_cnt = wrap ? '0 : cnt + {{(DIV_W-1){1'b0}}, 1'b1};
            next_rise = wrap;
        end
        if (i_div == '0) begin
            // ratio one: follow the input, keeping its duty cycle
            next_level = i_level;
            next_rise = i_rise;
        end else begin
            next_level = ({1'b0, next_cnt} < half);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt <= '0;
            o_level <= 1'b0;
            o_rise <= 1'b0;
        end else begin
            cnt <= next_cnt;
            o_level <= next_level;
            o_rise <= next_rise;
        end
    end

endmodule : mcg_edge_div

// File: design/mcg_master_clock.sv
// master clock generator: bypass prescalers, digital pll, cpu and system clocks
`timescale 1ns/10ps
`include "mcg_clock_map.svh"

// Contract
// - clock config register picks bypass prescalers or pll as master clock source.
// - cpu clock equals master clock, or half of it when the halve bit is set.
// - peripheral system clock has the same frequency as the cpu clock.
// - bypass: master clock is oscillator over (input div + 1) times (output div + 1).
// - bypass with both dividers zero: master clock follows the oscillator, same duty.
// - input divider up to 3, output divider up to 14; slowest bypass is osc/60.
// - source code 11 enables the pll, which then supplies the master clock.
// - pll: master is osc times (mult + 1) over (in div + 1) times (out div + 1).
// - pll pulls into lock gradually, with no abrupt master frequency steps.
// - with the pll selected, master clock is the vco output divided by output divider value plus one.
// - band code 00/01/10 sets 100-150/150-200/200-250 mhz vco; 11 is reserved.
module mcg_master_clock #(
    parameter int MUL_W = 5,
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // oscillator input pin, sampled
    input wire logic i_oscillator_input_pin,
    // clock generator configuration fields
    input wire logic [1:0] i_clock_source_select,
    input wire logic [1:0] i_input_divider_value,
    input wire logic [3:0] i_output_divider_value,
    input wire logic [MUL_W-1:0] i_loop_multiplier_value,
    input wire logic [1:0] i_vco_band_select,
    // system configuration
    input wire logic i_cpu_clock_halve,
    // generated clocks
    output logic o_master_clock,
    output logic o_cpu_clock,
    output logic o_peripheral_system_clock,
    // status
    output logic o_pll_selected,
    output logic o_pll_locked,
    output logic o_band_reserved
);

    localparam int ACC_W = `MCG_ACC_W;
    // nco step for a vco frequency: f * 2^acc_w / ref rate
    localparam logic [ACC_W:0] STEP_100 = (ACC_W+1)'((`MCG_VCO_100_MHZ << ACC_W) / `MCG_REF_MHZ);
    localparam logic [ACC_W:0] STEP_150 = (ACC_W+1)'((`MCG_VCO_150_MHZ << ACC_W) / `MCG_REF_MHZ);
    localparam logic [ACC_W:0] STEP_200 = (ACC_W+1)'((`MCG_VCO_200_MHZ << ACC_W) / `MCG_REF_MHZ);
    localparam logic [ACC_W:0] STEP_250 = (ACC_W+1)'((`MCG_VCO_250_MHZ << ACC_W) / `MCG_REF_MHZ);

    // ------------------------------------------------------------
    // configuration register and oscillator sampling
    // ------------------------------------------------------------
    logic [1:0] cfg_src;
    logic [1:0] cfg_idiv;
    logic [3:0] cfg_odiv;
    logic [MUL_W-1:0] cfg_mul;
    logic [1:0] cfg_band;
    logic band_rsvd;
    logic [1:0] next_cfg_src;
    logic [1:0] next_cfg_idiv;
    logic [3:0] next_cfg_odiv;
    logic [1:0] next_cfg_band;
    logic next_band_rsvd;
    logic osc_q;
    logic osc_d;
    logic osc_rise;

    always_comb begin
        next_cfg_src = i_clock_source_select;
        // out-of-range divider settings saturate at the documented maximum
        next_cfg_idiv = i_input_divider_value;
        next_cfg_odiv = (i_output_divider_value > `MCG_ODIV_MAX) ? `MCG_ODIV_MAX
                                                                 : i_output_divider_value;
        // reserved band code is refused: previous band stays in force
        next_band_rsvd = (i_vco_band_select == `MCG_BAND_RSVD);
        next_cfg_band = next_band_rsvd ? cfg_band : i_vco_band_select;
        osc_rise = osc_q & ~osc_d;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cfg_src <= `MCG_RST_SRC;
            cfg_idiv <= `MCG_RST_IDIV;
            cfg_odiv <= `MCG_RST_ODIV;
            cfg_mul <= '0;
            cfg_band <= `MCG_RST_BAND;
            band_rsvd <= 1'b0;
            osc_q <= 1'b0;
            osc_d <= 1'b0;
        end else begin
            cfg_src <= next_cfg_src;
            cfg_idiv <= next_cfg_idiv;
            cfg_odiv <= next_cfg_odiv;
            cfg_mul <= i_loop_multiplier_value;
            cfg_band <= next_cfg_band;
            band_rsvd <= next_band_rsvd;
            osc_q <= i_oscillator_input_pin;
            osc_d <= osc_q;
        end
    end

    // ------------------------------------------------------------
    // prescalers: input divider shared, output divider per path
    // ------------------------------------------------------------
    logic idiv_level;
    logic idiv_rise;
    logic byp_level;
    logic vco_level;
    logic vco_rise;
    logic pll_level;

    mcg_edge_div #(.DIV_W(2)) u_in_div (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_level(osc_d),
        .i_rise(osc_rise),
        .i_div(cfg_idiv),
        .o_level(idiv_level),
        .o_rise(idiv_rise)
    );

    mcg_edge_div #(.DIV_W(4)) u_byp_out_div (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_level(idiv_level),
        .i_rise(idiv_rise),
        .i_div(cfg_odiv),
        .o_level(byp_level),
        .o_rise()
    );

    mcg_edge_div #(.DIV_W(4)) u_pll_out_div (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_level(vco_level),
        .i_rise(vco_rise),
        .i_div(cfg_odiv),
        .o_level(pll_level),
        .o_rise()
    );

    // ------------------------------------------------------------
    // digital pll: nco steered by vco edges counted per reference edge
    // ------------------------------------------------------------
    logic pll_en;
    logic pll_run;
    logic sel_pll;
    logic [ACC_W-1:0] acc;
    logic [ACC_W:0] step;
    logic [CNT_W-1:0] vco_cnt;
    logic [3:0] match_cnt;
    mcg_clock_pkg::mcg_lock_state_t lock_st;
    logic [ACC_W-1:0] next_acc;
    logic [ACC_W:0] next_step;
    logic [CNT_W-1:0] next_vco_cnt;
    logic [3:0] next_match_cnt;
    mcg_clock_pkg::mcg_lock_state_t next_lock_st;
    logic next_vco_rise;
    logic [ACC_W:0] acc_sum;
    logic [ACC_W:0] step_min;
    logic [ACC_W:0] step_max;
    logic [CNT_W-1:0] target;

    always_comb begin
        pll_en = (cfg_src == `MCG_SRC_PLL);
        // vco keeps running until the source switch has left it
        pll_run = pll_en | sel_pll;
        case (cfg_band)
            `MCG_BAND_MID: begin
                step_min = STEP_150;
                step_max = STEP_200;
            end
            `MCG_BAND_HIGH: begin
                step_min = STEP_200;
                step_max = STEP_250;
            end
            default: begin
                step_min = STEP_100;
                step_max = STEP_150;
            end
        endcase
        target = CNT_W'({1'b0, cfg_mul} + 1);
        acc_sum = {1'b0, acc} + step;
        next_acc = pll_run ? acc_sum[ACC_W-1:0] : '0;
        next_vco_rise = pll_run & ~acc[ACC_W-1] & acc_sum[ACC_W-1];
        next_step = step;
        next_vco_cnt = vco_cnt;
        next_match_cnt = match_cnt;
        next_lock_st = lock_st;
        if (vco_rise && vco_cnt != '1) begin
            next_vco_cnt = vco_cnt + CNT_W'(1);
        end
        if (!pll_en) begin
            // hold the vco rate while it still drives the master clock
            next_step = sel_pll ? step : step_min;
            next_vco_cnt = '0;
            next_match_cnt = '0;
            next_lock_st = mcg_clock_pkg::MCG_ACQUIRE;
        end else if (idiv_rise) begin
            // one step per reference edge keeps the frequency slewing smoothly
            // a vco edge on the window boundary opens the next window
            next_vco_cnt = vco_rise ? CNT_W'(1) : '0;
            if (vco_cnt < target && step < step_max) begin
                next_step = step + (ACC_W+1)'(1);
            end else if (vco_cnt > target && step > step_min) begin
                next_step = step - (ACC_W+1)'(1);
            end
            if (step < step_min) begin
                next_step = step + (ACC_W+1)'(1);
            end else if (step > step_max) begin
                next_step = step - (ACC_W+1)'(1);
            end
            case (lock_st)
                mcg_clock_pkg::MCG_ACQUIRE: begin
                    next_match_cnt = (vco_cnt == target) ? match_cnt + 4'h1 : 4'h0;
                    if (next_match_cnt >= `MCG_LOCK_WINDOWS) begin
                        next_lock_st = mcg_clock_pkg::MCG_LOCKED;
                    end
                end
                mcg_clock_pkg::MCG_LOCKED: begin
                    next_match_cnt = '0;
                    if (vco_cnt + CNT_W'(1) < target || vco_cnt > target + CNT_W'(1)) begin
                        next_lock_st = mcg_clock_pkg::MCG_ACQUIRE;
                    end
                end
                default: begin
                    next_lock_st = mcg_clock_pkg::MCG_ACQUIRE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            acc <= '0;
            step <= STEP_100;
            vco_cnt <= '0;
            match_cnt <= '0;
            lock_st <= mcg_clock_pkg::MCG_ACQUIRE;
            vco_level <= 1'b0;
            vco_rise <= 1'b0;
        end else begin
            acc <= next_acc;
            step <= next_step;
            vco_cnt <= next_vco_cnt;
            match_cnt <= next_match_cnt;
            lock_st <= next_lock_st;
            vco_level <= next_acc[ACC_W-1];
            vco_rise <= next_vco_rise;
        end
    end

    // ------------------------------------------------------------
    // glitch-free source switch and cpu / system clocks
    // ------------------------------------------------------------
    logic halve_act;
    logic next_sel_pll;
    logic next_halve_act;
    logic next_mc;
    logic next_cpu;
    logic next_locked;

    always_comb begin
        next_sel_pll = sel_pll;
        next_halve_act = halve_act;
        // change source only while the output and the new source are both low
        if (!o_master_clock && !(pll_en ? pll_level : byp_level)) begin
            next_sel_pll = pll_en;
        end
        next_mc = next_sel_pll ? pll_level : byp_level;
        // change the cpu ratio only while master and cpu clocks are both low
        if (!o_master_clock && !o_cpu_clock && !next_mc) begin
            next_halve_act = i_cpu_clock_halve;
        end
        if (!next_halve_act) begin
            next_cpu = next_mc;
        end else if (next_mc && !o_master_clock) begin
            next_cpu = ~o_cpu_clock;
        end else begin
            next_cpu = o_cpu_clock;
        end
        next_locked = (next_lock_st == mcg_clock_pkg::MCG_LOCKED);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            sel_pll <= 1'b0;
            halve_act <= 1'b0;
            o_master_clock <= 1'b0;
            o_cpu_clock <= 1'b0;
            o_peripheral_system_clock <= 1'b0;
            o_pll_selected <= 1'b0;
            o_pll_locked <= 1'b0;
            o_band_reserved <= 1'b0;
        end else begin
            sel_pll <= next_sel_pll;
            halve_act <= next_halve_act;
            o_master_clock <= next_mc;
            o_cpu_clock <= next_cpu;
            o_peripheral_system_clock <= next_cpu;
            o_pll_selected <= next_sel_pll;
            o_pll_locked <= next_locked;
            o_band_reserved <= next_band_rsvd;
        end
    end

endmodule : mcg_master_clock

// File: verification/mcg_osc_model.sv
// free-running oscillator model driving the oscillator input pin
`timescale 1ns/10ps
module mcg_osc_model (
    // reference clock
    input wire logic i_ref_clk,
    // phase lengths in reference cycles
    input wire logic [7:0] i_high_cycles,
    input wire logic [7:0] i_low_cycles,
    // oscillator pin
    output logic o_oscillator_input_pin
);
    // ----
    // waveform, runs free like a real crystal
    // ----
    initial begin
        o_oscillator_input_pin = 1'b0;
        forever begin
            repeat (i_low_cycles) @(posedge i_ref_clk);
            #1 o_oscillator_input_pin = 1'b1;
            repeat (i_high_cycles) @(posedge i_ref_clk);
            #1 o_oscillator_input_pin = 1'b0;
        end
    end
endmodule : mcg_osc_model

// File: verification/mcg_master_clock_asserts.sv
// port checker for the master clock generator
`timescale 1ns/10ps
module mcg_master_clock_asserts #(
    parameter int MUL_W = 5,
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // inputs
    input wire logic i_oscillator_input_pin,
    input wire logic [1:0] i_clock_source_select,
    input wire logic [1:0] i_input_divider_value,
    input wire logic [3:0] i_output_divider_value,
    input wire logic [MUL_W-1:0] i_loop_multiplier_value,
    input wire logic [1:0] i_vco_band_select,
    input wire logic i_cpu_clock_halve,
    // outputs
    input wire logic o_master_clock,
    input wire logic o_cpu_clock,
    input wire logic o_peripheral_system_clock,
    input wire logic o_pll_selected,
    input wire logic o_pll_locked,
    input wire logic o_band_reserved
);
    // ----
    // helper counters
    // ----
    logic [2:0] up_cnt;
    logic [2:0] next_up_cnt;
    logic [3:0] dir_cnt;
    logic [3:0] next_dir_cnt;
    always_comb begin
        next_up_cnt = (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
        next_dir_cnt = 4'h0;
        if (i_clock_source_select != 2'h3 && i_input_divider_value == 2'h0
            && i_output_divider_value == 4'h0) begin
            next_dir_cnt = (dir_cnt == 4'hF) ? dir_cnt : dir_cnt + 4'h1;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            up_cnt <= 3'h0;
            dir_cnt <= 4'h0;
        end else begin
            up_cnt <= next_up_cnt;
            dir_cnt <= next_dir_cnt;
        end
    end
    // ----
    // assertions
    // ----
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_periph_same_cpu: assert property (o_peripheral_system_clock == o_cpu_clock)
        else $error("system clock differs from cpu clock");
    a_cpu_rise_master: assert property ($rose(o_cpu_clock) |-> $rose(o_master_clock))
        else $error("cpu clock rose without master rise");
    a_cpu_moves_master: assert property ($changed(o_cpu_clock) |-> $changed(o_master_clock))
        else $error("cpu clock moved between master edges");
    a_bypass_direct_follow: assert property ((dir_cnt == 4'hF && !o_pll_selected)
        |-> o_master_clock == $past(i_oscillator_input_pin, 5))
        else $error("master clock does not follow oscillator");
    a_band_reserved_flag: assert property ((up_cnt == 3'h7)
        |-> o_band_reserved == ($past(i_vco_band_select, 1) == 2'h3))
        else $error("reserved band flag wrong");
    a_pll_sel_rise: assert property ($rose(o_pll_selected)
        |-> $past(i_clock_source_select, 2) == 2'h3)
        else $error("pll selected without pll code");
    a_pll_sel_fall: assert property ($fell(o_pll_selected)
        |-> $past(i_clock_source_select, 2) != 2'h3)
        else $error("pll dropped while pll code held");
    a_switch_all_low: assert property ($changed(o_pll_selected)
        |-> !o_master_clock && !$past(o_master_clock))
        else $error("source switched while master high");
    c_pll_lock: cover property ($rose(o_pll_locked));
    c_cpu_halved: cover property ($rose(o_cpu_clock) && i_cpu_clock_halve);
    c_band_refused: cover property ($rose(o_band_reserved));
endmodule : mcg_master_clock_asserts

bind mcg_master_clock mcg_master_clock_asserts #(.MUL_W(MUL_W), .CNT_W(CNT_W)) chk_u (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_oscillator_input_pin(i_oscillator_input_pin),
    .i_clock_source_select(i_clock_source_select),
    .i_input_divider_value(i_input_divider_value),
    .i_output_divider_value(i_output_divider_value),
    .i_loop_multiplier_value(i_loop_multiplier_value),
    .i_vco_band_select(i_vco_band_select),
    .i_cpu_clock_halve(i_cpu_clock_halve),
    .o_master_clock(o_master_clock),
    .o_cpu_clock(o_cpu_clock),
    .o_peripheral_system_clock(o_peripheral_system_clock),
    .o_pll_selected(o_pll_selected),
    .o_pll_locked(o_pll_locked),
    .o_band_reserved(o_band_reserved)
);

// File: verification/tb.sv
// self-checking bench for the master clock generator
`timescale 1ns/10ps
module tb;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic pin;
    logic [1:0] src = 2'h0;
    logic [1:0] idiv = 2'h0;
    logic [3:0] odiv = 4'h0;
    logic [4:0] mul = 5'h00;
    logic [1:0] band = 2'h0;
    logic halve = 1'b0;
    logic [7:0] osc_hi = 8'h02;
    logic [7:0] osc_lo = 8'h02;
    logic mclk, cclk, sclk, psel, plock, bres;
    int err_count = 0;
    int num_checks = 0;
    int per, per2, hi;
    int iv[6] = '{0, 1, 0, 3, 2, 1};
    int ov[6] = '{0, 0, 1, 14, 4, 15};
    initial begin
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    mcg_osc_model osc_u (.i_ref_clk(i_ref_clk), .i_high_cycles(osc_hi),
        .i_low_cycles(osc_lo), .o_oscillator_input_pin(pin));
    mcg_master_clock #(.MUL_W(5), .CNT_W(8)) dut_u (.i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n), .i_oscillator_input_pin(pin), .i_clock_source_select(src),
        .i_input_divider_value(idiv), .i_output_divider_value(odiv),
        .i_loop_multiplier_value(mul), .i_vco_band_select(band),
        .i_cpu_clock_halve(halve), .o_master_clock(mclk), .o_cpu_clock(cclk),
        .o_peripheral_system_clock(sclk), .o_pll_selected(psel), .o_pll_locked(plock),
        .o_band_reserved(bres));
    // ----
    // helpers
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick
    function automatic logic pick(input int sel);
        case (sel)
            0: return mclk;
            1: return cclk;
            default: return sclk;
        endcase
    endfunction : pick
    // total cycles and high cycles over n periods of the chosen clock
    task automatic meas(input int sel, input int n, output int cyc, output int h);
        int k;
        logic prev;
        k = 0;
        cyc = 0;
        h = 0;
        prev = 1'b1;
        while (k <= n) begin
            tick(1);
            if (k > 0) cyc++;
            if (k > 0 && prev === 1'b1) h++;
            if (pick(sel) === 1'b1 && prev === 1'b0) k++;
            prev = pick(sel);
        end
    endtask : meas
    // ----
    // tests
    // ----
    initial begin
        #240000;
        err_count++;
        print_verdict();
    end
    initial begin
        tick(20);
        i_rst_n = 1'b1;
        tick(5);
        // bypass ratios, last entry has the output divider out of range
        for (int t = 0; t < 6; t++) begin
            idiv = iv[t][1:0];
            odiv = ov[t][3:0];
            tick(260);
            meas(0, 2, per, hi);
            chk(per, 8 * (iv[t] + 1) * ((ov[t] > 14 ? 14 : ov[t]) + 1));
        end
        osc_hi = 8'h03;
        osc_lo = 8'h05;
        idiv = 2'h0;
        odiv = 4'h0;
        tick(40);
        meas(0, 4, per, hi);
        chk(per, 32);
        chk(hi, 12);
        for (int h = 0; h < 2; h++) begin
            halve = ~h[0];
            tick(40);
            meas(1, 2, per, hi);
            meas(2, 2, per2, hi);
            chk(per, 16 * (2 - h));
            chk(per2, 16 * (2 - h));
        end
        // pll: 40-cycle oscillator, times 16, output divide 4
        osc_hi = 8'h14;
        osc_lo = 8'h14;
        mul = 5'h0F;
        odiv = 4'h3;
        src = 2'h3;
        for (int w = 0; w < 40000 && plock !== 1'b1; w++) tick(1);
        tick(200);
        chk(psel, 1'b1);
        meas(0, 16, per, hi);
        chk(per >= 158 && per <= 162, 1'b1);
        band = 2'h3;
        tick(4);
        chk(bres, 1'b1);
        meas(0, 16, per, hi);
        chk(per >= 158 && per <= 162, 1'b1);
        chk(plock, 1'b1);
        band = 2'h0;
        tick(4);
        chk(bres, 1'b0);
        for (int s = 2; s >= 0; s--) begin
            src = s[1:0];
            tick(300);
            chk(psel, 1'b0);
        end
        meas(0, 2, per, hi);
        chk(per, 320);
        print_verdict();
    end
endmodule : tb
